// >>> hdl/cdd_pkg.sv
// Package: register map, descriptor layout and states of the crypto DMA
package cdd_pkg;
    localparam logic [7:0] OFS_CONTROL = 8'h00;
    localparam logic [7:0] OFS_CUR_ADDR = 8'h04;
    localparam logic [7:0] OFS_BASE_ADDR = 8'h08;
    localparam logic [7:0] OFS_STATUS = 8'h0C;
    localparam logic [7:0] OFS_IRQ_SOURCE = 8'h10;
    localparam logic [7:0] OFS_IRQ_ENABLE = 8'h14;
    localparam logic [7:0] OFS_POLL_INTERVAL = 8'h18;
    localparam logic [7:0] OFS_HEADER_SKIP = 8'h1C;
    localparam logic [7:0] OFS_TRAILER_SKIP = 8'h20;
    localparam logic [7:0] OFS_IRQ_CLEAR = 8'h24;
    // Control register fields
    localparam int CTL_DMA_EN = 0;
    localparam int CTL_POLL_EN = 1;
    localparam int CTL_FETCH_EN = 2;
    localparam int CTL_RX_MODE = 3;
    // Interrupt source / enable fields
    localparam int IRQ_PEND = 0;
    localparam int IRQ_DESC = 1;
    localparam int IRQ_PKT = 2;
    localparam int IRQ_AERR = 3;
    // Descriptor control word fields
    localparam int DC_OWNED = 31;
    localparam int DC_MODE_HI = 29;
    localparam int DC_MODE_LO = 27;
    localparam int DC_ASSOC_FETCH = 22;
    localparam int DC_CHAIN_END = 19;
    localparam int DC_FRAME_END = 18;
    localparam int DC_PKT_IRQ = 17;
    localparam int DC_EACH_IRQ = 16;
    // Descriptor word indices
    localparam logic [2:0] DW_CONTROL = 3'h0;
    localparam logic [2:0] DW_ASSOC = 3'h1;
    localparam logic [2:0] DW_SOURCE = 3'h2;
    localparam logic [2:0] DW_DEST = 3'h3;
    localparam logic [2:0] DW_NEXT = 3'h4;
    localparam logic [2:0] DW_RESULT = 3'h5;
    localparam logic [2:0] DW_MSGLEN = 3'h6;
    localparam logic [2:0] DW_CIPHER_OFS = 3'h7;
    localparam int DESC_WORDS = 8;
    localparam logic [31:0] RESET_WORD = 32'h0000_0000;
    typedef enum logic [2:0] {
        MODE_NORMAL = 3'h0,
        MODE_PREBOOT_AUTH = 3'h1,
        MODE_KEY_ENC_KEY = 3'h2,
        MODE_CONTENT_ENC_KEY = 3'h3,
        MODE_RESERVED = 3'h4
    } cdd_mode_t;
    typedef enum logic [3:0] {
        ST_IDLE = 4'h0,
        ST_FETCH = 4'h1,
        ST_ASSOC = 4'h3,
        ST_READ = 4'h2,
        ST_WRITE = 4'h6,
        ST_BACK = 4'h7,
        ST_DONE = 4'h5,
        ST_POLL = 4'h4,
        ST_STOP = 4'hC
    } cdd_state_t;
endpackage

// >>> hdl/cdd_dma.sv
// Crypto descriptor DMA front end: APB registers and descriptor walker
// Function
// - Source bit 0 reads as OR of all engine interrupt flags.
// - Bit 3 sets when a memory access returns an error response.
// - Bit 2 sets when a whole packet is finished.
// - Bit 1 sets once the latest descriptor has been processed.
// - Enable bits 3..1 are read-write and reset to zero.
// - Enable bit 0 is a master gate over all interrupts.
// - Disabled descriptor: wait poll count cycles, then refetch control.
// - Skip header length locations before writing packet data.
// - Skip trailer length locations after packet end before next.
// - Bit 31 ownership; hardware clears it after processing.
// - Control bits 29-27 decode crypto mode; 100-111 reserved.
// - Bit 22 set fetches association via pointer, else keep current.
// - Chain end bit 19: reload current address from base.
// - Receive writes bit 18 multi-descriptor flag; transmit marks frame end.
// - Bit 17 raises interrupt after descriptor only at packet end.
// - Bit 16 raises interrupt after every processed descriptor.
// - Bits 15-0 buffer length; receive overwrites with bytes filled.
// - Descriptor is eight words in fixed order.
// - Second word is the security association pointer.
// - Fetching starts from the programmed base address.
// - Poll enable keeps polling until owned; clear means no polling.
`timescale 1ns/1ps
module cdd_dma #(
    parameter int POLL_W = 16
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic mem_req,
    output logic mem_write,
    output logic [31:0] mem_addr,
    output logic [31:0] mem_wdata,
    input wire logic mem_ack,
    input wire logic mem_err,
    input wire logic [31:0] mem_rdata,
    output logic [31:0] assoc_addr,
    output cdd_pkg::cdd_mode_t crypto_operation_mode,
    output logic irq
);
    import cdd_pkg::*;

    if (POLL_W < 1 || POLL_W > 16) begin : g_bad_poll
        $error("POLL_W must lie in 1..16");
    end

    function automatic cdd_mode_t decode_mode(input logic [2:0] code);
        case (code)
            3'h0: decode_mode = MODE_NORMAL;
            3'h1: decode_mode = MODE_PREBOOT_AUTH;
            3'h2: decode_mode = MODE_KEY_ENC_KEY;
            3'h3: decode_mode = MODE_CONTENT_ENC_KEY;
            default: decode_mode = MODE_RESERVED;
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////////
    logic [3:0] control_q;
    logic [31:0] base_q;
    logic [31:0] cur_q;
    logic [3:1] flags_q;
    logic [3:0] irq_en_q;
    logic [POLL_W-1:0] poll_wait_cycles_q;
    logic [7:0] header_skip_len_q;
    logic [7:0] trailer_skip_len_q;
    logic [31:0] desc_q [DESC_WORDS];
    cdd_state_t state_q;
    logic [2:0] widx_q;
    logic [POLL_W-1:0] poll_cnt_q;
    logic [15:0] words_left_q;
    logic [15:0] bytes_done_q;
    logic [31:0] src_q;
    logic [31:0] dst_q;
    logic [31:0] data_q;
    logic [31:0] assoc_q;
    logic in_packet_q;
    logic multi_q;
    logic [7:0] gap_q;
    logic wr_en;
    logic rd_ok;
    logic [31:0] wb_word;
    logic desc_finish;
    logic pkt_end;
    logic err_hit;
    logic [3:1] set_flags;
    logic [3:1] clr_flags;
    logic pending;

    assign wr_en = psel && penable && pwrite;
    assign pkt_end = desc_q[DW_CONTROL][DC_FRAME_END];
    assign desc_finish = state_q == ST_DONE;
    assign err_hit = mem_req && mem_ack && mem_err;

    ////////////////////////////////////////////////////////////////////////
    // Registers written by software
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            control_q <= '0;
            base_q <= RESET_WORD;
            irq_en_q <= '0;
            poll_wait_cycles_q <= '0;
            header_skip_len_q <= '0;
            trailer_skip_len_q <= '0;
        end else if (wr_en) begin
            case (paddr[7:0])
                OFS_CONTROL: control_q <= pwdata[3:0];
                OFS_BASE_ADDR: base_q <= pwdata;
                OFS_IRQ_ENABLE: irq_en_q <= pwdata[3:0];
                OFS_POLL_INTERVAL: poll_wait_cycles_q <= pwdata[POLL_W-1:0];
                OFS_HEADER_SKIP: header_skip_len_q <= pwdata[7:0];
                OFS_TRAILER_SKIP: trailer_skip_len_q <= pwdata[7:0];
                default: control_q <= control_q;
            endcase
        end
    end

    // Sticky flags; a set in the clearing cycle wins
    always_comb begin
        set_flags = '0;
        set_flags[IRQ_AERR] = err_hit;
        set_flags[IRQ_PKT] = desc_finish && pkt_end;
        set_flags[IRQ_DESC] = desc_finish
            && (desc_q[DW_CONTROL][DC_EACH_IRQ]
            || (desc_q[DW_CONTROL][DC_PKT_IRQ] && pkt_end));
    end
    assign clr_flags = (wr_en && paddr[7:0] == OFS_IRQ_CLEAR)
        ? pwdata[3:1] : 3'h0;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flags_q <= '0;
        end else begin
            flags_q <= (flags_q & ~clr_flags) | set_flags;
        end
    end

    assign pending = |flags_q;
    assign irq = irq_en_q[IRQ_PEND] && |(flags_q & irq_en_q[3:1]);

    ////////////////////////////////////////////////////////////////////////
    // APB read side, zero wait states
    assign pready = 1'b1;
    always_comb begin
        rd_ok = 1'b1;
        prdata = '0;
        case (paddr[7:0])
            OFS_CONTROL: prdata[3:0] = control_q;
            OFS_CUR_ADDR: prdata = cur_q;
            OFS_BASE_ADDR: prdata = base_q;
            OFS_STATUS: prdata = {8'h00, 2'b00, state_q, 1'b0,
                state_q != ST_IDLE, desc_q[DW_CONTROL][15:0]};
            OFS_IRQ_SOURCE: prdata[3:0] = {flags_q, pending};
            OFS_IRQ_ENABLE: prdata[3:0] = irq_en_q;
            OFS_POLL_INTERVAL: prdata[POLL_W-1:0] = poll_wait_cycles_q;
            OFS_HEADER_SKIP: prdata[7:0] = header_skip_len_q;
            OFS_TRAILER_SKIP: prdata[7:0] = trailer_skip_len_q;
            OFS_IRQ_CLEAR: prdata = '0;
            default: rd_ok = 1'b0;
        endcase
    end
    assign pslverr = psel && penable && (!rd_ok || paddr[1:0] != 2'b00);

    ////////////////////////////////////////////////////////////////////////
    // Memory master; request held until acknowledged
    always_comb begin
        mem_req = 1'b0;
        mem_write = 1'b0;
        mem_addr = cur_q + {27'h0, widx_q, 2'b00};
        mem_wdata = data_q;
        case (state_q)
            ST_FETCH: mem_req = 1'b1;
            ST_ASSOC: begin
                mem_req = 1'b1;
                mem_addr = desc_q[DW_ASSOC];
            end
            ST_READ: begin
                mem_req = 1'b1;
                mem_addr = src_q;
            end
            ST_WRITE: begin
                mem_req = 1'b1;
                mem_write = 1'b1;
                mem_addr = dst_q;
            end
            ST_BACK: begin
                mem_req = 1'b1;
                mem_write = 1'b1;
                mem_addr = cur_q;
                mem_wdata = wb_word;
            end
            default: mem_req = 1'b0;
        endcase
    end

    // Ownership handed back; length and frame bit updated in receive mode only
    always_comb begin
        wb_word = desc_q[DW_CONTROL];
        wb_word[DC_OWNED] = 1'b0;
        if (control_q[CTL_RX_MODE]) begin
            wb_word[DC_FRAME_END] = multi_q;
            wb_word[15:0] = bytes_done_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Descriptor processor
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q <= ST_IDLE;
            cur_q <= RESET_WORD;
            widx_q <= '0;
            poll_cnt_q <= '0;
            words_left_q <= '0;
            bytes_done_q <= '0;
            src_q <= RESET_WORD;
            dst_q <= RESET_WORD;
            data_q <= RESET_WORD;
            in_packet_q <= 1'b0;
            multi_q <= 1'b0;
            gap_q <= '0;
        end else if (!control_q[CTL_DMA_EN]) begin
            // Disabling drops any transfer; descriptor memory is left as is
            state_q <= ST_IDLE;
            in_packet_q <= 1'b0;
            gap_q <= '0;
        end else if (err_hit) begin
            state_q <= ST_STOP;
        end else begin
            case (state_q)
                ST_IDLE: begin
                    if (control_q[CTL_FETCH_EN]) begin
                        cur_q <= base_q;
                        widx_q <= DW_CONTROL;
                        state_q <= ST_FETCH;
                    end
                end
                ST_FETCH: begin
                    if (mem_ack) begin
                        widx_q <= widx_q + 3'h1;
                        if (widx_q == DW_CONTROL
                                && !mem_rdata[DC_OWNED]) begin
                            widx_q <= DW_CONTROL;
                            poll_cnt_q <= poll_wait_cycles_q;
                            state_q <= control_q[CTL_POLL_EN]
                                ? ST_POLL : ST_STOP;
                        end else if (widx_q == DW_CIPHER_OFS) begin
                            src_q <= desc_q[DW_SOURCE];
                            dst_q <= desc_q[DW_DEST]
                                + (in_packet_q ? 32'h0
                                : {21'h0, 9'(gap_q) + 9'(header_skip_len_q),
                                2'b00});
                            words_left_q <= 16'(({1'b0,
                                desc_q[DW_CONTROL][15:0]} + 17'h3) >> 2);
                            bytes_done_q <= '0;
                            multi_q <= in_packet_q || !pkt_end;
                            state_q <= desc_q[DW_CONTROL][DC_ASSOC_FETCH]
                                ? ST_ASSOC : ST_READ;
                        end
                    end
                end
                ST_POLL: begin
                    if (poll_cnt_q == '0) begin
                        state_q <= ST_FETCH;
                    end else begin
                        poll_cnt_q <= poll_cnt_q - 1'b1;
                    end
                end
                ST_ASSOC: begin
                    if (mem_ack) begin
                        state_q <= ST_READ;
                    end
                end
                ST_READ: begin
                    if (words_left_q == '0) begin
                        state_q <= ST_BACK;
                    end else if (mem_ack) begin
                        data_q <= mem_rdata;
                        src_q <= src_q + 32'h4;
                        state_q <= ST_WRITE;
                    end
                end
                ST_WRITE: begin
                    if (mem_ack) begin
                        dst_q <= dst_q + 32'h4;
                        words_left_q <= words_left_q - 16'h1;
                        bytes_done_q <= (words_left_q == 16'h1)
                            ? desc_q[DW_CONTROL][15:0]
                            : bytes_done_q + 16'h4;
                        state_q <= ST_READ;
                    end
                end
                ST_BACK: begin
                    if (mem_ack) begin
                        state_q <= ST_DONE;
                    end
                end
                ST_DONE: begin
                    in_packet_q <= !pkt_end;
                    gap_q <= pkt_end ? trailer_skip_len_q : 8'h00;
                    cur_q <= desc_q[DW_CONTROL][DC_CHAIN_END]
                        ? base_q : desc_q[DW_NEXT];
                    widx_q <= DW_CONTROL;
                    state_q <= control_q[CTL_FETCH_EN] ? ST_FETCH : ST_IDLE;
                end
                ST_STOP: begin
                    // Parked until software drops fetch enable
                    if (!control_q[CTL_FETCH_EN]) begin
                        state_q <= ST_IDLE;
                    end
                end
                default: state_q <= ST_IDLE;
            endcase
        end
    end

    // Captured descriptor words
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < DESC_WORDS; i++) begin
                desc_q[i] <= RESET_WORD;
            end
        end else if (state_q == ST_FETCH && mem_ack && !mem_err) begin
            desc_q[widx_q] <= mem_rdata;
        end
    end

    // Association in use; kept when the descriptor asks for no fetch
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            assoc_q <= RESET_WORD;
        end else if (state_q == ST_ASSOC && mem_ack && !mem_err) begin
            assoc_q <= desc_q[DW_ASSOC];
        end
    end
    assign assoc_addr = assoc_q;
    assign crypto_operation_mode =
        decode_mode(desc_q[DW_CONTROL][DC_MODE_HI:DC_MODE_LO]);

    ////////////////////////////////////////////////////////////////////////
    sequence s_unowned_seen;
        state_q == ST_FETCH && widx_q == DW_CONTROL && mem_ack && !mem_err
            && !mem_rdata[DC_OWNED] && control_q[CTL_DMA_EN];
    endsequence

    a_pending_or: assert property (@(posedge pclk) disable iff (!presetn)
        (pending == |flags_q) && (prdata[0] == pending
        || paddr[7:0] != OFS_IRQ_SOURCE))
        else $error("pending flag not OR of sources");
    a_error_sets: assert property (@(posedge pclk) disable iff (!presetn)
        err_hit |=> flags_q[IRQ_AERR] && state_q == ST_STOP)
        else $error("access error not recorded");
    a_packet_flag: assert property (@(posedge pclk) disable iff (!presetn)
        desc_finish && pkt_end |=> flags_q[IRQ_PKT])
        else $error("packet flag missed");
    a_irq_gate: assert property (@(posedge pclk) disable iff (!presetn)
        irq |-> irq_en_q[IRQ_PEND] && |(flags_q & irq_en_q[3:1]))
        else $error("interrupt without enabled source");
    a_master_gate: assert property (@(posedge pclk) disable iff (!presetn)
        !irq_en_q[IRQ_PEND] |-> !irq)
        else $error("interrupt with master off");
    a_poll_wait: assert property (@(posedge pclk) disable iff (!presetn)
        (s_unowned_seen and (control_q[CTL_POLL_EN] && !err_hit))
        |=> state_q == ST_POLL && poll_cnt_q == poll_wait_cycles_q)
        else $error("poll wait not loaded");
    a_no_poll: assert property (@(posedge pclk) disable iff (!presetn)
        (s_unowned_seen and !control_q[CTL_POLL_EN]) |=> state_q == ST_STOP)
        else $error("polled with polling off");
    a_owner_clear: assert property (@(posedge pclk) disable iff (!presetn)
        state_q == ST_BACK && mem_req |-> !mem_wdata[DC_OWNED])
        else $error("ownership not returned");
    a_chain_reload: assert property (@(posedge pclk) disable iff (!presetn)
        desc_finish && desc_q[DW_CONTROL][DC_CHAIN_END]
        && control_q[CTL_DMA_EN] |=> cur_q == $past(base_q))
        else $error("chain end did not reload base");
    a_start_base: assert property (@(posedge pclk) disable iff (!presetn)
        state_q == ST_IDLE && control_q[CTL_FETCH_EN] && control_q[CTL_DMA_EN]
        |=> state_q == ST_FETCH && cur_q == $past(base_q))
        else $error("fetch did not start at base");
    a_desc_flag: assert property (@(posedge pclk) disable iff (!presetn)
        desc_finish && desc_q[DW_CONTROL][DC_EACH_IRQ] |=> flags_q[IRQ_DESC])
        else $error("descriptor flag missed");
    a_pkt_irq: assert property (@(posedge pclk) disable iff (!presetn)
        desc_finish && !pkt_end && !desc_q[DW_CONTROL][DC_EACH_IRQ]
        && !flags_q[IRQ_DESC] |=> !flags_q[IRQ_DESC])
        else $error("packet request fired mid packet");
endmodule // cdd_dma

// >>> tb/cdd_mem_model.sv
// Memory model: word store answering the descriptor walker
`timescale 1ns/1ps
module cdd_mem_model (
    input wire logic pclk,
    input wire logic mem_req,
    input wire logic mem_write,
    input wire logic [31:0] mem_addr,
    input wire logic [31:0] mem_wdata,
    input wire logic slow,
    input wire logic [31:0] err_addr,
    output logic mem_ack,
    output logic mem_err,
    output logic [31:0] mem_rdata
);
    // Descriptors, association and buffers; filled by the bench
    logic [31:0] mem [0:255];
    logic [1:0] wait_q;
    initial begin
        mem_ack = 1'b0;
        mem_err = 1'b0;
        mem_rdata = 32'h0000_0000;
        wait_q = 2'h0;
    end
    ////////////////////////////////////////////////////////////
    // Read data flips outside an answer, so stale data never matches
    always @(posedge pclk) begin
        mem_ack <= 1'b0;
        mem_err <= 1'b0;
        mem_rdata <= ~mem_rdata;
        if (mem_req && !mem_ack) begin
            if (slow && wait_q != 2'h3) begin
                wait_q <= wait_q + 2'h1;
            end else begin
                wait_q <= 2'h0;
                mem_ack <= 1'b1;
                mem_err <= (mem_addr == err_addr);
                mem_rdata <= mem[mem_addr[9:2]];
            end
        end
        if (mem_req && mem_ack && mem_write && !mem_err) begin
            mem[mem_addr[9:2]] <= mem_wdata;
        end
    end
endmodule // cdd_mem_model

// >>> tb/tb.sv
// Testbench: registers, descriptor walk, skips, polling and errors
`timescale 1ns/1ps
module tb;
    import cdd_pkg::*;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
    logic mem_req, mem_write, mem_ack, mem_err, slow, ev;
    logic [31:0] paddr, pwdata, prdata, mem_addr, mem_wdata, mem_rdata;
    logic [31:0] assoc_addr, err_addr, rv;
    cdd_mode_t crypto_operation_mode;
    int miscompares, comparisons;
    cdd_dma i_cdd_dma (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .mem_req(mem_req), .mem_write(mem_write),
        .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_ack(mem_ack),
        .mem_err(mem_err), .mem_rdata(mem_rdata),
        .assoc_addr(assoc_addr),
        .crypto_operation_mode(crypto_operation_mode), .irq(irq));
    cdd_mem_model i_mem (.pclk(pclk), .mem_req(mem_req),
        .mem_write(mem_write), .mem_addr(mem_addr),
        .mem_wdata(mem_wdata), .slow(slow), .err_addr(err_addr),
        .mem_ack(mem_ack), .mem_err(mem_err), .mem_rdata(mem_rdata));
    ////////////////////////////////////////////////////////////
    task automatic close_out();
        $display("comparisons %0d miscompares %0d", comparisons,
            miscompares);
        if (miscompares == 0 && comparisons > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    task automatic chk(input string n, input logic [31:0] e,
        input logic [31:0] g);
        comparisons++;
        if (g !== e) begin
            miscompares++;
            $display("MISMATCH %s exp %h got %h", n, e, g);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge pclk);
    endtask
    task automatic tmo(input int n);
        if (n >= 300) begin
            miscompares++;
            close_out();
        end
    endtask
    task automatic bus(input logic w, input logic [7:0] a,
        input logic [31:0] d);
        int n;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {24'h0, a};
        pwdata <= d;
        cyc(1);
        penable <= 1'b1;
        n = 0;
        do begin
            cyc(1);
            n++;
        end while (pready !== 1'b1 && n < 300);
        rv = prdata;
        ev = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        tmo(n);
        cyc(1);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e,
        input string n);
        bus(1'b0, a, 32'h0);
        chk(n, e, rv);
    endtask
    // Descriptor at 0x100 (aligned), data 0x200 to 0x300
    task automatic pkt(input logic [31:0] ctl, input logic [3:0] cr,
        input logic [31:0] sa);
        int n;
        logic [31:0] d [8];
        wr(OFS_CONTROL, 32'h0);
        d = '{ctl, sa, 32'h200, 32'h300, 32'h140, 0, 4, 0};
        for (int i = 0; i < 8; i++) i_mem.mem[64 + i] = d[i];
        i_mem.mem[128] = 32'hA5A5_0001;
        i_mem.mem[129] = 32'hA5A5_0002;
        i_mem.mem[192] = 32'h0;
        wr(OFS_IRQ_CLEAR, 32'hE);
        wr(OFS_BASE_ADDR, 32'h100);
        wr(OFS_CONTROL, {28'h0, cr});
        n = 0;
        while (i_mem.mem[64][31] !== 1'b0 && !(mem_ack && mem_err)
            && n < 300) begin
            cyc(1);
            n++;
        end
        tmo(n);
        cyc(4);
    endtask
    ////////////////////////////////////////////////////////////
    task automatic s_regs();
        rd(OFS_IRQ_ENABLE, 0, "enable rst");
        rd(OFS_POLL_INTERVAL, 0, "poll rst");
        rd(OFS_HEADER_SKIP, 0, "header rst");
        rd(OFS_TRAILER_SKIP, 0, "trailer rst");
        wr(OFS_IRQ_ENABLE, '1);
        rd(OFS_IRQ_ENABLE, 32'hF, "enable rw");
        wr(OFS_POLL_INTERVAL, '1);
        rd(OFS_POLL_INTERVAL, 32'hFFFF, "poll rw");
        wr(OFS_HEADER_SKIP, '1);
        rd(OFS_HEADER_SKIP, 32'hFF, "header rw");
        wr(OFS_TRAILER_SKIP, '1);
        rd(OFS_TRAILER_SKIP, 32'hFF, "trailer rw");
        wr(OFS_IRQ_SOURCE, '1);
        rd(OFS_IRQ_SOURCE, 0, "source ro");
        chk("irq idle", 0, irq);
        bus(1'b0, 8'h40, 0);
        chk("unmapped", 1, ev);
        wr(OFS_IRQ_ENABLE, 0);
        wr(OFS_POLL_INTERVAL, 0);
        wr(OFS_HEADER_SKIP, 0);
        wr(OFS_TRAILER_SKIP, 0);
    endtask
    // Every mode, reserved one last as code 110; spare bits left zero
    task automatic s_modes();
        logic [31:0] m;
        for (int k = 0; k < 5; k++) begin
            m = {2'h0, (k == 4) ? 3'h6 : 3'(k), 27'h0};
            pkt(32'h804D_0004 | m, 4'h5, 32'h400);
            chk("back", 32'h004D_0004 | m, i_mem.mem[64]);
            chk("mode", (k == 4) ? 4 : k, 32'(crypto_operation_mode));
            chk("moved", 32'hA5A5_0001, i_mem.mem[192]);
            chk("assoc", 32'h400, assoc_addr);
            rd(OFS_IRQ_SOURCE, 32'h7, "source");
            rd(OFS_CUR_ADDR, 32'h100, "cur");
        end
        wr(OFS_IRQ_ENABLE, 32'h6);
        chk("no master", 0, irq);
        wr(OFS_IRQ_ENABLE, 32'h7);
        chk("irq", 1, irq);
    endtask
    task automatic s_flags();
        pkt(32'h800E_0004, 4'h5, 32'h440);
        rd(OFS_IRQ_SOURCE, 32'h7, "end pkt");
        chk("kept assoc", 32'h400, assoc_addr);
        pkt(32'h800A_0004, 4'h5, 32'h440);
        rd(OFS_IRQ_SOURCE, 32'h0, "mid pkt");
        chk("irq off", 0, irq);
    endtask
    // Polling keeps the walker enabled, so the trailer gap survives
    task automatic s_skip();
        int n;
        wr(OFS_HEADER_SKIP, 2);
        wr(OFS_TRAILER_SKIP, 3);
        slow <= 1'b1;
        pkt(32'h804D_0004, 4'h7, 32'h400);
        chk("header", 32'hA5A5_0001, i_mem.mem[194]);
        i_mem.mem[197] = 32'h0;
        i_mem.mem[64] = 32'h804D_0004;
        n = 0;
        while (i_mem.mem[64][31] !== 1'b0 && n < 300) begin
            cyc(1);
            n++;
        end
        tmo(n);
        cyc(4);
        chk("skip", 32'hA5A5_0001, i_mem.mem[197]);
        slow <= 1'b0;
    endtask
    task automatic s_rx();
        pkt(32'h804D_0008, 4'hD, 32'h400);
        chk("rx back", 32'h0049_0008, i_mem.mem[64]);
    endtask
    task automatic s_err();
        wr(OFS_IRQ_ENABLE, 32'h9);
        err_addr <= 32'h200;
        pkt(32'h804D_0004, 4'h5, 32'h400);
        rd(OFS_IRQ_SOURCE, 32'h9, "acc err");
        chk("err irq", 1, irq);
        err_addr <= 32'hFFFF_FFFC;
    endtask
    task automatic s_poll();
        int n;
        wr(OFS_CONTROL, 0);
        i_mem.mem[64] = 32'h0009_0004;
        wr(OFS_POLL_INTERVAL, 6);
        wr(OFS_CONTROL, 7);
        n = 0;
        while (!(mem_ack && mem_addr == 32'h100) && n < 300) begin
            cyc(1);
            n++;
        end
        tmo(n);
        cyc(1);
        n = 0;
        while (mem_req !== 1'b1 && n < 300) begin
            cyc(1);
            n++;
        end
        chk("gap", 1, 32'(n >= 6 && n <= 9));
        chk("refetch", 32'h100, mem_addr);
        i_mem.mem[64] = 32'h8009_0004;
        n = 0;
        while (i_mem.mem[64][31] !== 1'b0 && n < 300) begin
            cyc(1);
            n++;
        end
        chk("polled", 0, i_mem.mem[64][31]);
        wr(OFS_CONTROL, 0);
        i_mem.mem[64] = 32'h0009_0004;
        wr(OFS_CONTROL, 5);
        cyc(30);
        chk("no poll", 0, mem_req);
    endtask
    ////////////////////////////////////////////////////////////
    initial begin
        pclk = 1'b0;
        forever #4 pclk = ~pclk;
    end
    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 32'h0;
        pwdata = 32'h0;
        slow = 1'b0;
        err_addr = 32'hFFFF_FFFC;
        miscompares = 0;
        comparisons = 0;
        cyc(10);
        presetn <= 1'b1;
        cyc(1);
        s_regs();
        s_modes();
        s_flags();
        s_skip();
        s_rx();
        s_err();
        s_poll();
        close_out();
    end
endmodule // tb
